// ==== core/pio_pkg.sv ====
// Function
// - Three 8-bit ports, per-pin pull-up control except port 2 pins 7..3
// - Pull-up disable bits clear after reset
// - Pull-up disabled pin only drives low
// - Port 0 disable bit n kills pull-up
// - Port 1 disable bit n kills pull-up
// - Latch bit captures bus on write strobe
// - Latch read returns stored latch value
// - Pin read returns synchronised pin level
// - Read-modify-write reads latch, others read pin
// - Enabled peripheral owns its pin
// - Latch 0 drives low, 1 pulls weakly
// - Modulated pin drives latch XOR square wave
// - Config bit 4 gates all modulation
// - Eight select bits, all clear at reset
// - Select bits map to eight fixed pins
// - Port 2 disable: bit 5 reset pin, 2..0
// - Port 2 pin 3 reads back as one on a pin read; a latch read returns its latch bit
`default_nettype none
package pio_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_PORT1 = 8'h90;
  localparam logic [7:0] ADDR_MOD_SEL = 8'h9F;
  localparam logic [7:0] ADDR_PORT2 = 8'hA0;
  localparam logic [7:0] ADDR_PUDIS0 = 8'hB2;
  localparam logic [7:0] ADDR_PUDIS1 = 8'hB3;
  localparam logic [7:0] ADDR_PUDIS2 = 8'hB4;
  // ==========================================================
  // Reset values and field layout
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] PUDIS_RST = 8'h00;
  localparam logic [7:0] MOD_SEL_RST = 8'h00;
  localparam logic [7:0] PUDIS2_MASK = 8'h27; // Bits 5,2,1,0 writable
  localparam int PUDIS2_RST_PIN_BIT = 5;
  localparam int PORT2_WO_BIT = 3; // Output-only pin
  localparam int CFG_MOD_EN_BIT = 4;
  localparam int NUM_PINS = 24;
  localparam int NUM_MOD = 8;
  // Pin index (port*8+pin) for each select bit, bit 0 first
  localparam logic [4:0] MOD_PIN_IDX [NUM_MOD] = '{5'h03, 5'h05, 5'h07, 5'h02,
                                                  5'h09, 5'h13, 5'h0D, 5'h0E};
  // ==========================================================
  // Modulation timing
  localparam int CORE_FREQ_HZ = 25000000;
  localparam int MOD_FREQ_HZ = 38000;
  // Half period rounded to nearest whole cycle
  localparam int MOD_HALF_CYC = (CORE_FREQ_HZ + MOD_FREQ_HZ) / (2 * MOD_FREQ_HZ);
  localparam int MOD_CNT_W = 9;
  // ==========================================================
  // Special function register request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd_latch;
    logic rd_pin;
  } pio_sfr_req_type;
endpackage : pio_pkg
`default_nettype wire

// ==== core/pio_sync.sv ====
`default_nettype none
module pio_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // ==========================================================
  // Two-stage synchroniser
  logic [WIDTH-1:0] meta_reg; // First stage, read only by second
  // Pads idle high under pull-ups, so reset to ones
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pio_sync
`default_nettype wire

// ==== core/pio_pin.sv ====
`default_nettype none
module pio_pin (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Controls
  input wire logic latch_bit,
  input wire logic mod_on,
  input wire logic mod_wave,
  input wire logic alt_en,
  input wire logic alt_out,
  // Pad driver
  output logic pad_oe_n
);
  // ==========================================================
  // Output level choice
  wire logic gp_level; // General purpose level after modulation
  wire logic out_level; // Level the pin should show
  assign gp_level = latch_bit ^ (mod_on & mod_wave);
  assign out_level = alt_en ? alt_out : gp_level;
  // Driver only sinks; a high level is left to pull-up or float
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pad_oe_n <= 1'b1;
    end else begin
      pad_oe_n <= out_level;
    end
  end
endmodule : pio_pin
`default_nettype wire

// ==== core/pio_ports.sv ====
`default_nettype none
module pio_ports (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // CPU register access
  input wire pio_pkg::pio_sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // Configuration register from core
  input wire logic [7:0] cfg_reg,
  // Peripheral ownership
  input wire logic [pio_pkg::NUM_PINS-1:0] alt_en,
  input wire logic [pio_pkg::NUM_PINS-1:0] alt_out,
  output logic [pio_pkg::NUM_PINS-1:0] pin_level,
  // Pads
  input wire logic [pio_pkg::NUM_PINS-1:0] pad_in,
  output logic [pio_pkg::NUM_PINS-1:0] pad_out,
  output logic [pio_pkg::NUM_PINS-1:0] pad_oe_n,
  output logic [pio_pkg::NUM_PINS-1:0] pad_pu_en,
  output logic rst_pin_pu_en
);
  import pio_pkg::*;

  // ==========================================================
  // Register state
  logic [7:0] latch0_reg; // Port 0 bit latches
  logic [7:0] latch1_reg; // Port 1 bit latches
  logic [7:0] latch2_reg; // Port 2 bit latches
  logic [7:0] pudis0_reg; // Port 0 pull-up disables
  logic [7:0] pudis1_reg; // Port 1 pull-up disables
  logic [7:0] pudis2_reg; // Port 2 pull-up disables
  logic [7:0] mod_sel_reg; // Per-pin modulation select
  logic [7:0] rdata_next; // Read mux
  logic [MOD_CNT_W-1:0] mod_cnt_reg; // Half period counter
  logic [MOD_CNT_W-1:0] mod_cnt_next;
  logic mod_wave_reg; // Square wave
  logic mod_wave_next;

  // ==========================================================
  // Address decode
  wire logic sel_p0 = (sfr_req.addr == ADDR_PORT0);
  wire logic sel_p1 = (sfr_req.addr == ADDR_PORT1);
  wire logic sel_p2 = (sfr_req.addr == ADDR_PORT2);
  wire logic sel_ms = (sfr_req.addr == ADDR_MOD_SEL);
  wire logic sel_u0 = (sfr_req.addr == ADDR_PUDIS0);
  wire logic sel_u1 = (sfr_req.addr == ADDR_PUDIS1);
  wire logic sel_u2 = (sfr_req.addr == ADDR_PUDIS2);
  wire logic sel_any = sel_p0 | sel_p1 | sel_p2 | sel_ms | sel_u0 | sel_u1 | sel_u2;
  wire logic rd_any = sfr_req.rd_latch | sfr_req.rd_pin;
  // Tells the core this block answers the address
  assign sfr_hit = sel_any;

  // ==========================================================
  // Pin sampling
  logic [NUM_PINS-1:0] pin_sync; // Synchronised pad levels
  pio_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(pad_in),
    .sync_out(pin_sync)
  );
  // Peripherals see the same synchronised levels
  assign pin_level = pin_sync;

  // Port 2 output-only pin never reflects the pad in a port read
  wire logic [7:0] pin2_view; // Port 2 pin read value
  assign pin2_view = pin_sync[23:16] | (8'h01 << PORT2_WO_BIT);

  // ==========================================================
  // Read mux: the core picks latch or pin path per instruction
  always_comb begin
    rdata_next = 8'h00;
    if (sfr_req.rd_latch) begin
      if (sel_p0) rdata_next = latch0_reg;
      if (sel_p1) rdata_next = latch1_reg;
      if (sel_p2) rdata_next = latch2_reg;
    end else if (sfr_req.rd_pin) begin
      if (sel_p0) rdata_next = pin_sync[7:0];
      if (sel_p1) rdata_next = pin_sync[15:8];
      if (sel_p2) rdata_next = pin2_view;
    end
    // Configuration registers read the same on either path
    if (rd_any) begin
      if (sel_ms) rdata_next = mod_sel_reg;
      if (sel_u0) rdata_next = pudis0_reg;
      if (sel_u1) rdata_next = pudis1_reg;
      if (sel_u2) rdata_next = pudis2_reg;
    end
  end

  // Read data registered; unmapped reads give zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (rd_any) begin
      sfr_rdata <= rdata_next;
    end
  end

  // ==========================================================
  // Port latches
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latch0_reg <= LATCH_RST;
      latch1_reg <= LATCH_RST;
      latch2_reg <= LATCH_RST;
    end else if (sfr_req.wr) begin
      if (sel_p0) latch0_reg <= sfr_req.wdata;
      if (sel_p1) latch1_reg <= sfr_req.wdata;
      if (sel_p2) latch2_reg <= sfr_req.wdata;
    end
  end

  // ==========================================================
  // Pull-up and modulation configuration
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pudis0_reg <= PUDIS_RST;
      pudis1_reg <= PUDIS_RST;
      pudis2_reg <= PUDIS_RST;
      mod_sel_reg <= MOD_SEL_RST;
    end else if (sfr_req.wr) begin
      if (sel_u0) pudis0_reg <= sfr_req.wdata;
      if (sel_u1) pudis1_reg <= sfr_req.wdata;
      // Reserved bits cannot be set, so they read zero
      if (sel_u2) pudis2_reg <= sfr_req.wdata & PUDIS2_MASK;
      if (sel_ms) mod_sel_reg <= sfr_req.wdata;
    end
  end

  // Each pin has its own enable; ports 2 pins 7..3 have none
  assign pad_pu_en[7:0] = ~pudis0_reg;
  assign pad_pu_en[15:8] = ~pudis1_reg;
  assign pad_pu_en[23:16] = {5'h1F, ~pudis2_reg[2:0]};
  assign rst_pin_pu_en = ~pudis2_reg[PUDIS2_RST_PIN_BIT];
  // Pads only ever sink current
  assign pad_out = '0;

  // ==========================================================
  // Square wave divider
  wire logic mod_glob_en = cfg_reg[CFG_MOD_EN_BIT];
  wire logic cnt_wrap = (mod_cnt_reg == MOD_CNT_W'(MOD_HALF_CYC - 1));
  // Held in reset while disabled to save toggling power
  always_comb begin
    mod_cnt_next = mod_cnt_reg + MOD_CNT_W'(1);
    mod_wave_next = mod_wave_reg;
    if (!mod_glob_en) begin
      mod_cnt_next = '0;
      mod_wave_next = 1'b0;
    end else if (cnt_wrap) begin
      mod_cnt_next = '0;
      mod_wave_next = ~mod_wave_reg;
    end
  end

  // Divider state
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mod_cnt_reg <= '0;
      mod_wave_reg <= 1'b0;
    end else begin
      mod_cnt_reg <= mod_cnt_next;
      mod_wave_reg <= mod_wave_next;
    end
  end

  // ==========================================================
  // Modulation routing
  logic [NUM_PINS-1:0] mod_mask; // Pins whose select bit is set
  always_comb begin
    mod_mask = '0;
    for (int k = 0; k < NUM_MOD; k++) begin
      mod_mask[MOD_PIN_IDX[k]] = mod_sel_reg[k];
    end
  end

  // ==========================================================
  // Pin drivers
  wire logic [NUM_PINS-1:0] latch_all = {latch2_reg, latch1_reg, latch0_reg};
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    pio_pin u_pin (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .latch_bit(latch_all[i]),
      .mod_on(mod_mask[i]),
      .mod_wave(mod_wave_reg),
      .alt_en(alt_en[i]),
      .alt_out(alt_out[i]),
      .pad_oe_n(pad_oe_n[i])
    );
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_latch_write;
    sfr_req.wr && sel_p0 |=> latch0_reg == $past(sfr_req.wdata);
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("port 0 latch missed a write");

  property p_latch_read;
    sfr_req.rd_latch && sel_p1 |=> sfr_rdata == $past(latch1_reg);
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("latch read did not return latch");

  property p_pin_read;
    sfr_req.rd_pin && !sfr_req.rd_latch && sel_p0 |=> sfr_rdata == $past(pin_sync[7:0]);
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("pin read did not return pin level");

  property p_pu0;
    sfr_req.wr && sel_u0 |=> pad_pu_en[7:0] == ~$past(sfr_req.wdata);
  endproperty
  a_pu0: assert property (p_pu0)
    else $error("port 0 pull-up enables wrong after write");

  property p_pu1;
    sfr_req.wr && sel_u1 |=> pad_pu_en[15:8] == ~$past(sfr_req.wdata);
  endproperty
  a_pu1: assert property (p_pu1)
    else $error("port 1 pull-up enables wrong after write");

  property p_pu2_mask;
    sfr_req.wr && sel_u2 |=> pudis2_reg == ($past(sfr_req.wdata) & PUDIS2_MASK);
  endproperty
  a_pu2_mask: assert property (p_pu2_mask)
    else $error("port 2 pull-up disable reserved bits set");

  property p_drive_low;
    sfr_req.wr && sel_p0 && !sfr_req.wdata[0] && !alt_en[0] ##1 !alt_en[0]
      |=> !pad_oe_n[0];
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("latch zero did not drive pin low");

  property p_wo_pin;
    sfr_req.rd_pin && !sfr_req.rd_latch && sel_p2 |=> sfr_rdata[PORT2_WO_BIT];
  endproperty
  a_wo_pin: assert property (p_wo_pin)
    else $error("output-only pin read back a pad level");

  property p_alt_owns;
    alt_en[9] |=> pad_oe_n[9] == $past(alt_out[9]);
  endproperty
  a_alt_owns: assert property (p_alt_owns)
    else $error("peripheral did not own its pin");

  property p_mod_off;
    !mod_glob_en |=> !mod_wave_reg && mod_cnt_reg == '0;
  endproperty
  a_mod_off: assert property (p_mod_off)
    else $error("square wave ran while disabled");

  property p_half_period;
    mod_glob_en && $past(mod_glob_en) && $changed(mod_wave_reg)
      |-> $past(mod_cnt_reg) == MOD_CNT_W'(MOD_HALF_CYC - 1);
  endproperty
  a_half_period: assert property (p_half_period)
    else $error("square wave half period wrong");

  property p_mod_xor;
    mod_sel_reg[7] && !alt_en[14] |=> pad_oe_n[14] == ($past(latch1_reg[6]) ^
      $past(mod_wave_reg));
  endproperty
  a_mod_xor: assert property (p_mod_xor)
    else $error("modulated pin is not latch xor wave");

  // Main scenarios
  c_wave_toggle: cover property (mod_glob_en && $changed(mod_wave_reg));
  c_open_drain_in: cover property (pudis0_reg[0] && latch0_reg[0] && !pin_sync[0]);
  c_mod_burst: cover property (mod_sel_reg[0] && !latch0_reg[3] && mod_wave_reg);
  c_rmw_read: cover property (sfr_req.rd_latch && sel_p2);
endmodule : pio_ports
`default_nettype wire

// ==== tb/pio_ext_model.sv ====
`default_nettype none
module pio_ext_model (
  // Clock
  input wire logic core_clk,
  // Device pad drivers
  input wire logic [23:0] pad_oe_n,
  input wire logic [23:0] pad_pu_en,
  // Outside devices sinking the wire
  input wire logic [23:0] ext_low,
  // Resolved wire level
  output logic [23:0] pad_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven wire wanders every cycle, so no stale level can pass
  logic [23:0] float_pat = 24'h5A5A5A;
  always @(posedge core_clk) begin
    float_pat <= ~float_pat;
  end
  // Wired-AND of both sinks, else pull-up, else floating
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (!pad_oe_n[i] || ext_low[i]) begin
        pad_lvl[i] = 1'b0;
      end else if (pad_pu_en[i]) begin
        pad_lvl[i] = 1'b1;
      end else begin
        pad_lvl[i] = float_pat[i];
      end
    end
  end
endmodule : pio_ext_model
`default_nettype wire

// ==== tb/parallel_io_ports_pin_modulation_select_bits_tb_top.sv ====
`default_nettype none
module parallel_io_ports_pin_modulation_select_bits_tb_top import pio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Stimulus and observed signals
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  pio_sfr_req_type sfr_req = '0;
  logic [7:0] cfg_reg = 8'h00;
  logic [23:0] alt_en = '0, alt_out = '0, ext_low = '0;
  logic [7:0] sfr_rdata;
  logic sfr_hit, rst_pin_pu_en;
  logic [23:0] pin_level, pad_in, pad_out, pad_oe_n, pad_pu_en;
  // Reference model state
  logic [7:0] lat [3];
  logic [7:0] pud [3];
  logic [7:0] msel;
  int midx [8] = '{3, 5, 7, 2, 9, 19, 13, 14}; // Select bit to pin index
  logic [7:0] addrs [$] = '{ADDR_PORT0, ADDR_PORT1, ADDR_PORT2, ADDR_MOD_SEL,
                            ADDR_PUDIS0, ADDR_PUDIS1, ADDR_PUDIS2, 8'h55};
  int errors = 0;
  int checks_done = 0;
  int n;
  logic prev;
  pio_ports i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .cfg_reg(cfg_reg), .alt_en(alt_en),
    .alt_out(alt_out), .pin_level(pin_level), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_pu_en(pad_pu_en), .rst_pin_pu_en(rst_pin_pu_en));
  pio_ext_model i_ext (.core_clk(core_clk), .pad_oe_n(pad_oe_n),
    .pad_pu_en(pad_pu_en), .ext_low(ext_low), .pad_lvl(pad_in));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // ==========================================
  // Reference model
  function automatic logic [23:0] exp_oe(input logic wave);
    logic [23:0] v;
    v = {lat[2], lat[1], lat[0]};
    for (int b = 0; b < 8; b++) begin
      if (msel[b] && cfg_reg[4]) v[midx[b]] ^= wave;
    end
    return (v & ~alt_en) | (alt_out & alt_en); // Owner overrides latch
  endfunction : exp_oe
  function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic pin);
    logic [23:0] lvl;
    lvl = exp_oe(1'b0) & ~ext_low;
    lvl[19] = 1'b1; // Output-only pin reads high
    case (a)
      ADDR_PORT0: return pin ? lvl[7:0] : lat[0];
      ADDR_PORT1: return pin ? lvl[15:8] : lat[1];
      ADDR_PORT2: return pin ? lvl[23:16] : lat[2];
      ADDR_MOD_SEL: return msel;
      ADDR_PUDIS0: return pud[0];
      ADDR_PUDIS1: return pud[1];
      ADDR_PUDIS2: return pud[2];
      default: return 8'h00;
    endcase
  endfunction : exp_rd
  // ==========================================
  // Shared checks and bus cycles
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
  endtask : tick
  // Write cycle, mirrored into the model; reserved port 2 bits stay clear
  task automatic wr_m(input logic [7:0] a, input logic [7:0] d);
    sfr_req <= '{addr: a, wdata: d, wr: 1'b1, rd_latch: 1'b0, rd_pin: 1'b0};
    tick(1);
    sfr_req <= '0;
    tick(1);
    for (int p = 0; p < 3; p++) begin
      if (a == addrs[p]) lat[p] = d;
      if (a == addrs[4 + p]) pud[p] = (p == 2) ? (d & 8'h27) : d;
    end
    if (a == ADDR_MOD_SEL) msel = d;
  endtask : wr_m
  // Read every place, mapped or not, by one path
  task automatic rd_all(input logic pin);
    foreach (addrs[k]) begin
      sfr_req <= '{addr: addrs[k], wdata: 8'h00, wr: 1'b0, rd_latch: !pin, rd_pin: pin};
      // Request still stands at this edge, so the decode is settled
      tick(1);
      chk("hit", sfr_hit, addrs[k] != 8'h55);
      sfr_req <= '0;
      tick(1);
      // Read data was launched one edge earlier and now holds
      chk("read", sfr_rdata, exp_rd(addrs[k], pin));
    end
  endtask : rd_all
  task automatic pins_ok();
    tick(4);
    chk("oe", pad_oe_n, exp_oe(1'b0));
    chk("level", pin_level, exp_oe(1'b0) & ~ext_low);
  endtask : pins_ok
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  // ==========================================
  // Watchdog, far beyond the roughly one thousand cycles needed
  initial begin
    tick(20000);
    errors++;
    test_done();
  end
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(70));
    lat = '{8'hFF, 8'hFF, 8'hFF};
    pud = '{8'h00, 8'h00, 8'h00};
    msel = 8'h00;
    tick(2);
    sys_rst <= 1'b0;
    tick(1);
    // Unmapped write ignored, then reset values; latches high allow input use
    wr_m(8'h55, 8'hA5);
    ext_low <= 24'($urandom);
    rd_all(1'b0);
    rd_all(1'b1);
    // Random latches against outside sinks, both read paths
    repeat (6) begin
      for (int p = 0; p < 3; p++) wr_m(addrs[p], 8'($urandom));
      ext_low <= 24'($urandom);
      pins_ok();
      rd_all(1'b0);
      rd_all(1'b1);
    end
    // Peripheral ownership, latches kept high beforehand
    for (int p = 0; p < 3; p++) wr_m(addrs[p], 8'hFF);
    alt_en <= 24'($urandom) | 24'h000200; // Pin 9 always owned here
    alt_out <= 24'($urandom);
    pins_ok();
    alt_en <= '0;
    // Modulation: selected but globally off, then on
    for (int p = 0; p < 3; p++) wr_m(addrs[p], 8'($urandom));
    wr_m(ADDR_MOD_SEL, 8'hFF);
    pins_ok();
    cfg_reg <= 8'h10;
    for (int r = 0; r < 2; r++) begin
      prev = pad_oe_n[3];
      n = 0;
      do begin
        tick(1);
        #1;
        n++;
      end while (pad_oe_n[3] === prev && n < 700);
      // Wave is high after the first toggle, low again after the second
      chk("mod oe", pad_oe_n, exp_oe(r == 0));
    end
    chk("half period", n, MOD_HALF_CYC);
    tick(1);
    cfg_reg <= 8'h00;
    pins_ok();
    // Pull-up disables with reserved bits attempted
    for (int p = 0; p < 3; p++) wr_m(addrs[4 + p], 8'($urandom));
    rd_all(1'b0);
    chk("pullup", pad_pu_en, {5'h1F, ~pud[2][2:0], ~pud[1], ~pud[0]});
    chk("reset pullup", rst_pin_pu_en, !pud[2][5]);
    chk("pad out", pad_out, 24'h000000);
    // Mid-run reset must bring back every reset value
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    lat = '{8'hFF, 8'hFF, 8'hFF};
    pud = '{8'h00, 8'h00, 8'h00};
    msel = 8'h00;
    tick(1);
    rd_all(1'b0);
    rd_all(1'b1);
    chk("reset pullups", pad_pu_en, 24'hFFFFFF);
    test_done();
  end
endmodule : parallel_io_ports_pin_modulation_select_bits_tb_top
`default_nettype wire
